//--- common/brw_pkg.sv
package brw_pkg;
    // clock and watchdog timing
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned WD_BASE_MS = 125;
    localparam int unsigned WD_BASE_CYC = CLK_HZ / 1000 * WD_BASE_MS;
    localparam int unsigned WD_STEPS = 16;
    localparam int unsigned WD_SEL_W = 4;
    localparam int unsigned WD_CNT_W = 44;
    // board reset pulse length for edge sources
    localparam int unsigned RST_PULSE_US = 100;
    localparam int unsigned RST_PULSE_CYC = CLK_HZ / 1_000_000 * RST_PULSE_US;
    localparam int unsigned PULSE_W = 24;

    // register byte offsets
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_KICK = 4'h4;
    localparam logic [3:0] REG_STAT = 4'h8;
    localparam logic [3:0] REG_MASK = 4'hc;

    // ctrl fields
    localparam int unsigned CTRL_EN = 0;
    localparam int unsigned CTRL_MODE_LO = 1;
    localparam int unsigned CTRL_SEL_LO = 4;
    localparam int unsigned CTRL_PRST_EN = 8;
    localparam int unsigned CTRL_W = 9;

    // status / mask fields
    localparam int unsigned ST_WD_IRQ = 0;
    localparam int unsigned ST_WD_RESET = 1;
    localparam int unsigned ST_BTN = 2;
    localparam int unsigned ST_PRST = 3;
    localparam int unsigned ST_BPRST = 4;
    localparam int unsigned ST_W = 5;
    localparam int unsigned STAT_WD_CAUSE = 8;

    localparam logic [31:0] KICK_KEY = 32'h0000_00a5;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 9'h000;

    typedef enum logic [1:0] {
        WDM_RESET = 2'h0,
        WDM_IRQ = 2'h1,
        WDM_DUAL = 2'h2
    } brw_wdmode_t;

    typedef enum logic [2:0] {
        WS_IDLE = 3'b001,
        WS_RUN = 3'b010,
        WS_STAGE2 = 3'b100
    } brw_wdst_t;
endpackage : brw_pkg

//--- rtl/brw_edge_sync.sv
`timescale 1ns/10ps
// two-flop synchroniser with falling-edge pulse for active-low pins
module brw_edge_sync (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic pin_n_in,
    output logic level_out,
    output logic fall_out
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } brw_sync_t;

    brw_sync_t q_r;
    brw_sync_t q_nxt;

    always_comb begin
        q_nxt = q_r;
        q_nxt.s1 = pin_n_in;
        q_nxt.s2 = q_r.s1;
        q_nxt.s3 = q_r.s2;
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            q_r <= '1;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign level_out = ~q_r.s2;
    assign fall_out = q_r.s3 & ~q_r.s2;
endmodule : brw_edge_sync

//--- rtl/brw_reset_wdog.sv
// The implementer's own choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/10ps
module brw_reset_wdog
    import brw_pkg::*;
#(
    parameter int unsigned BASE_CYC = brw_pkg::WD_BASE_CYC,
    parameter int unsigned PULSE_CYC = brw_pkg::RST_PULSE_CYC
) (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // classic wishbone slave
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [3:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    output logic irq_out,
    // board pins, asynchronous; active low except periph_mode_in and the wd led outputs
    input wire logic supply_low_n_in,
    input wire logic conv_fail_n_in,
    input wire logic button_n_in,
    input wire logic bp_prst_n_in,
    input wire logic bp_rst_n_in,
    input wire logic periph_mode_in,
    output logic board_rst_n_out,
    output logic wd_active_out,
    output logic wd_expired_out
);
    import brw_pkg::*;

    // one register image; the board reset leaves it alone, only rst_n_in clears it
    typedef struct packed {
        logic [CTRL_W-1:0] ctrl;
        logic [ST_W-1:0] stat;
        logic [ST_W-1:0] mask;
        brw_wdst_t wst;
        logic [WD_CNT_W-1:0] cnt;
        logic [PULSE_W-1:0] pulse;
        logic wd_cause;
        logic ack;
        logic [31:0] rdat;
        logic irq;
        logic brst_n;
        logic expired;
        logic active;
    } brw_state_t;

    brw_state_t q_r;
    brw_state_t q_nxt;

    logic supply_low;
    logic conv_fail;
    logic btn_fall;
    logic prst_fall;
    logic bprst_fall;
    logic periph_sync;

    brw_edge_sync u_sup (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
        .pin_n_in(supply_low_n_in), .level_out(supply_low), .fall_out());
    brw_edge_sync u_conv (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
        .pin_n_in(conv_fail_n_in), .level_out(conv_fail), .fall_out());
    brw_edge_sync u_btn (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
        .pin_n_in(button_n_in), .level_out(), .fall_out(btn_fall));
    brw_edge_sync u_prst (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
        .pin_n_in(bp_prst_n_in), .level_out(), .fall_out(prst_fall));
    brw_edge_sync u_brst (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
        .pin_n_in(bp_rst_n_in), .level_out(), .fall_out(bprst_fall));
    // mode strap is inverted here so level_out gives the true level
    brw_edge_sync u_per (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
        .pin_n_in(~periph_mode_in), .level_out(periph_sync), .fall_out());

    logic [WD_SEL_W-1:0] sel;
    logic [WD_CNT_W-1:0] period;
    brw_wdmode_t mode;
    logic wr;
    logic rd_req;
    logic kick;
    logic expire;
    logic [ST_W-1:0] ev;
    logic edge_rst;
    logic level_rst;

    always_comb begin
        sel = q_r.ctrl[CTRL_SEL_LO +: WD_SEL_W];
        mode = brw_wdmode_t'(q_r.ctrl[CTRL_MODE_LO +: 2]);
        // doubling per step from the base period
        period = WD_CNT_W'(BASE_CYC) << sel;
        rd_req = wb_cyc_in & wb_stb_in & ~q_r.ack;
        wr = rd_req & wb_we_in;
        kick = wr && wb_adr_in == REG_KICK && wb_sel_in[0]
            && wb_dat_in[7:0] == KICK_KEY[7:0];
        expire = (q_r.wst != WS_IDLE) && (q_r.cnt == WD_CNT_W'(1));
    end

    always_comb begin
        q_nxt = q_r;
        ev = '0;
        edge_rst = 1'b0;
        level_rst = supply_low | conv_fail;

        // watchdog engine
        // expire is true in the last counted cycle, so a period lasts period cycles
        unique case (q_r.wst)
            WS_IDLE: begin
                q_nxt.cnt = period;
                if (q_r.ctrl[CTRL_EN]) begin
                    q_nxt.wst = WS_RUN;
                end
            end
            WS_RUN: begin
                q_nxt.cnt = q_r.cnt - WD_CNT_W'(1);
                if (expire) begin
                    q_nxt.expired = 1'b1;
                    q_nxt.cnt = period;
                    if (mode == WDM_IRQ) begin
                        ev[ST_WD_IRQ] = 1'b1;
                    end else if (mode == WDM_DUAL) begin
                        ev[ST_WD_IRQ] = 1'b1;
                        q_nxt.wst = WS_STAGE2;
                    end else begin
                        ev[ST_WD_RESET] = 1'b1;
                    end
                end
            end
            WS_STAGE2: begin
                q_nxt.cnt = q_r.cnt - WD_CNT_W'(1);
                if (expire) begin
                    ev[ST_WD_RESET] = 1'b1;
                    // reload so the reset repeats each period instead of wrapping
                    q_nxt.cnt = period;
                end
            end
            default: begin
                q_nxt.wst = WS_IDLE;
            end
        endcase
        // an expiry in the same cycle wins over a late kick
        if (kick && q_r.wst != WS_IDLE && !expire) begin
            q_nxt.cnt = period;
            q_nxt.wst = WS_RUN;
            q_nxt.expired = 1'b0;
        end
        if (!q_r.ctrl[CTRL_EN]) begin
            q_nxt.wst = WS_IDLE;
            q_nxt.expired = 1'b0;
        end
        // registered copy of the running state drives the led output
        q_nxt.active = q_nxt.wst != WS_IDLE;

        // only the falling edge counts; release of a pin is not an event
        ev[ST_BTN] = btn_fall;
        ev[ST_PRST] = prst_fall;
        ev[ST_BPRST] = bprst_fall & q_r.ctrl[CTRL_PRST_EN] & periph_sync;
        edge_rst = ev[ST_WD_RESET] | ev[ST_BTN] | ev[ST_PRST] | ev[ST_BPRST];

        // reset pulse generator; level sources hold it
        // an edge source keeps the board in reset for PULSE_CYC cycles; a new edge during the pulse reloads the count
        // level sources bypass the counter so release follows the pin
        if (edge_rst) begin
            q_nxt.pulse = PULSE_W'(PULSE_CYC);
        end else if (q_r.pulse != '0) begin
            q_nxt.pulse = q_r.pulse - PULSE_W'(1);
        end
        q_nxt.brst_n = ~(level_rst | edge_rst | (q_nxt.pulse != '0));

        // cause flag: latest reset decides; survives board reset
        if (ev[ST_WD_RESET]) begin
            q_nxt.wd_cause = 1'b1;
        end else if (level_rst | ev[ST_BTN] | ev[ST_PRST] | ev[ST_BPRST]) begin
            q_nxt.wd_cause = 1'b0;
        end

        // wishbone: one wait state, ack for one cycle
        q_nxt.ack = rd_req;
        q_nxt.rdat = '0;
        if (rd_req && !wb_we_in) begin
            unique case (wb_adr_in)
                REG_CTRL: q_nxt.rdat = 32'(q_r.ctrl);
                REG_STAT: begin
                    q_nxt.rdat = 32'(q_r.stat);
                    q_nxt.rdat[STAT_WD_CAUSE] = q_r.wd_cause;
                end
                REG_MASK: q_nxt.rdat = 32'(q_r.mask);
                // the kick register has no storage and reads zero
                REG_KICK: q_nxt.rdat = '0;
                default: q_nxt.rdat = '0;
            endcase
        end
        if (wr && wb_adr_in == REG_CTRL) begin
            if (wb_sel_in[0]) begin
                q_nxt.ctrl[7:0] = wb_dat_in[7:0];
            end
            if (wb_sel_in[1]) begin
                q_nxt.ctrl[CTRL_PRST_EN] = wb_dat_in[CTRL_PRST_EN];
            end
        end
        if (wr && wb_adr_in == REG_MASK && wb_sel_in[0]) begin
            q_nxt.mask = wb_dat_in[ST_W-1:0];
        end
        // write-one-to-clear; a new event wins over the clear
        if (wr && wb_adr_in == REG_STAT && wb_sel_in[0]) begin
            q_nxt.stat = q_r.stat & ~wb_dat_in[ST_W-1:0];
        end
        q_nxt.stat = q_nxt.stat | ev;
        // irq follows the next status and mask so it rises with the status bit
        q_nxt.irq = |(q_nxt.stat & q_nxt.mask);
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            q_r.ctrl <= CTRL_RESET;
            q_r.stat <= '0;
            q_r.mask <= '0;
            q_r.wst <= WS_IDLE;
            q_r.cnt <= '0;
            q_r.pulse <= '0;
            q_r.wd_cause <= 1'b0;
            q_r.ack <= 1'b0;
            q_r.rdat <= '0;
            q_r.irq <= 1'b0;
            q_r.brst_n <= 1'b0;
            q_r.expired <= 1'b0;
            q_r.active <= 1'b0;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign wb_dat_out = q_r.rdat;
    assign wb_ack_out = q_r.ack;
    assign irq_out = q_r.irq;
    assign board_rst_n_out = q_r.brst_n;
    assign wd_active_out = q_r.active;
    assign wd_expired_out = q_r.expired;
endmodule : brw_reset_wdog

//--- testbench/brw_reset_wdog_chk.sv
`timescale 1ns/10ps
module brw_reset_wdog_chk (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_ack_out,
    input wire logic [31:0] wb_dat_out,
    input wire logic supply_low_n_in,
    input wire logic conv_fail_n_in,
    input wire logic button_n_in,
    input wire logic bp_prst_n_in,
    input wire logic board_rst_n_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);
    // edge pins pass a two-flop synchroniser before the reset register
    sequence rst_soon;
        ##[2:5] !board_rst_n_out;
    endsequence
    a_ack_single: assert property (wb_ack_out |=> !wb_ack_out)
        else $error("ack held longer than one cycle");
    a_ack_answer: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
        else $error("request not answered next cycle");
    a_dat_quiet: assert property (!wb_ack_out |-> wb_dat_out == 32'h0)
        else $error("read data outside ack cycle");
    a_supply_hold: assert property (!supply_low_n_in [*5] |-> !board_rst_n_out)
        else $error("board out of reset while supply low");
    a_conv_hold: assert property (!conv_fail_n_in [*5] |-> !board_rst_n_out)
        else $error("board out of reset while converter failed");
    a_button_edge: assert property ($fell(button_n_in) |-> rst_soon)
        else $error("button press gave no reset");
    a_prst_edge: assert property ($fell(bp_prst_n_in) |-> rst_soon)
        else $error("prst edge gave no reset");
    // an edge source holds the board reset PULSE_CYC cycles, 5 in the bench
    a_pulse_min: assert property ($fell(board_rst_n_out) |-> !board_rst_n_out [*5])
        else $error("board reset pulse too short");
endmodule : brw_reset_wdog_chk
bind brw_reset_wdog brw_reset_wdog_chk u_chk (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
    .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_ack_out(wb_ack_out),
    .wb_dat_out(wb_dat_out), .supply_low_n_in(supply_low_n_in), .conv_fail_n_in(conv_fail_n_in),
    .button_n_in(button_n_in), .bp_prst_n_in(bp_prst_n_in), .board_rst_n_out(board_rst_n_out));

//--- testbench/brw_pins.sv
`timescale 1ns/10ps
// every board line has a pull-up; a source pulls it low only while told to
module brw_pins (
    input wire logic [4:0] pull_low_in,
    output logic [4:0] pin_n_out
);
    assign pin_n_out = ~pull_low_in;
endmodule : brw_pins

//--- testbench/brw_reset_wdog_bench.sv
`timescale 1ns/10ps
module brw_reset_wdog_bench;
    import brw_pkg::*;
    localparam int PULSE_LEN = 5;
    logic clk = 1'h0, rst_n = 1'h0, cyc = 1'h0, stb = 1'h0, we = 1'h0, periph = 1'h0;
    logic [3:0] adr = 4'h0;
    logic [31:0] wdat = 32'h0, rdat, q;
    logic [4:0] pl = 5'h0, pin_n;
    logic ack, irq, brst_n, act, exp_led;
    int mismatches = 0, checks_done = 0, low;
    initial forever #5 clk = ~clk;
    brw_pins pins (.pull_low_in(pl), .pin_n_out(pin_n));
    brw_reset_wdog #(.BASE_CYC(20), .PULSE_CYC(PULSE_LEN)) dut (.sys_clk_in(clk), .rst_n_in(rst_n),
        .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hf),
        .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack), .irq_out(irq),
        .supply_low_n_in(pin_n[0]), .conv_fail_n_in(pin_n[1]), .button_n_in(pin_n[2]),
        .bp_prst_n_in(pin_n[3]), .bp_rst_n_in(pin_n[4]), .periph_mode_in(periph),
        .board_rst_n_out(brst_n), .wd_active_out(act), .wd_expired_out(exp_led));
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wb(logic w, logic [3:0] a, logic [31:0] d);
        @(posedge clk);
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= a;
        wdat <= d;
        // ack and read data are taken at the rising edge that samples ack high
        do @(posedge clk); while (ack !== 1'h1);
        q = rdat;
        cyc <= 1'h0;
        stb <= 1'h0;
    endtask : wb
    task automatic pulse(int i, int len, output int lo);
        lo = 0;
        for (int k = 0; k < 45; k++) begin
            @(posedge clk);
            pl[i] <= (k < len);
            @(negedge clk);
            lo += (brst_n === 1'h0);
        end
    endtask : pulse
    task automatic wait_evt(bit rst, output int t);
        t = 0;
        do begin @(negedge clk); t++; end
        while (t < 300 && (rst ? brst_n !== 1'h0 : irq !== 1'h1));
    endtask : wait_evt
    task automatic t_idle;
        chk("board reset idle", brst_n, 1);
        wb(0, REG_CTRL, 0);
        chk("ctrl reset", q, 0);
        wb(0, 4'h2, 0);
        chk("unmapped", q, 0);
    endtask : t_idle
    task automatic t_edges;
        pulse(2, 20, low);
        chk("button pulse", low, PULSE_LEN);
        wb(0, REG_STAT, 0);
        chk("stat button", q, 32'h4);
        chk("irq masked", irq, 0);
        wb(1, REG_MASK, 32'h1f);
        chk("irq unmasked", irq, 1);
        wb(1, REG_STAT, 32'h1f);
        chk("irq cleared", irq, 0);
        pulse(3, 4, low);
        chk("prst pulse", low, PULSE_LEN);
        wb(1, REG_STAT, 32'h1f);
        periph <= 1'h1;
        pulse(4, 4, low);
        chk("bp rst disabled", low, 0);
        wb(1, REG_CTRL, 32'h100);
        pulse(4, 4, low);
        chk("bp rst enabled", low, PULSE_LEN);
        wb(0, REG_STAT, 0);
        chk("stat bp rst", q, 32'h10);
        wb(1, REG_STAT, 32'h1f);
        wb(1, REG_CTRL, 0);
        for (int i = 0; i < 2; i++) begin
            pulse(i, 30, low);
            chk("level hold", low inside {[28:33]}, 1);
        end
    endtask : t_edges
    task automatic t_wdog;
        int t;
        wb(1, REG_MASK, 32'h1);
        wb(1, REG_CTRL, 32'h1);
        // the engine leaves idle one cycle after the enable lands
        @(posedge clk);
        chk("wd running", act, 1);
        wait_evt(1, t);
        chk("wd reset time", t inside {[15:24]}, 1);
        wb(1, REG_CTRL, 0);
        wb(0, REG_STAT, 0);
        chk("wd cause", q & 32'h102, 32'h102);
        wb(1, REG_STAT, 32'h1f);
        // setting 1 must take twice the base period
        wb(1, REG_CTRL, 32'h13);
        wait_evt(0, t);
        chk("wd irq time", t inside {[35:44]}, 1);
        chk("wd irq only", brst_n, 1);
        wb(1, REG_CTRL, 0);
        wb(1, REG_STAT, 32'h1f);
        wb(1, REG_CTRL, 32'h5);
        wait_evt(0, t);
        chk("dual irq", {brst_n, t inside {[15:24]}}, 2'h3);
        chk("wd expired led", exp_led, 1);
        wait_evt(1, t);
        chk("dual reset", t inside {[16:24]}, 1);
        wb(1, REG_CTRL, 0);
        wb(1, REG_STAT, 32'h1f);
        wb(1, REG_CTRL, 32'h3);
        repeat (5) begin
            repeat (10) @(posedge clk);
            wb(1, REG_KICK, KICK_KEY);
        end
        chk("kicked no irq", irq, 0);
        chk("kicked no expiry", exp_led, 0);
        wb(1, REG_CTRL, 0);
        @(posedge clk);
        chk("wd stopped", act, 0);
    endtask : t_wdog
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : final_report
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'h1;
        repeat (4) @(posedge clk);
        t_idle;
        t_edges;
        t_wdog;
        final_report;
    end
    // the whole sequence needs well under 3000 cycles
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        final_report;
    end
endmodule : brw_reset_wdog_bench
